// file: verilog/swr_pkg.sv
package swr_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_SLEEP = 6'h15;
  localparam logic [5:0] IDX_WDCLR = 6'h16;
  localparam logic [5:0] IDX_OPMODE = 6'h17;
  localparam logic [5:0] IDX_LVD = 6'h1C;
  localparam logic [5:0] IDX_STAT = 6'h1D;

  localparam logic [7:0] SLEEP_CODE = 8'h5A;
  localparam logic [7:0] WDCLR_CODE = 8'hA5;
  localparam logic [7:0] OPMODE_RST = 8'h88;
  localparam logic [3:0] CAUSE_POR = 4'h1;

  localparam int OPM_CPU_FAST = 7;
  localparam int OPM_RTC_EN = 3;
  localparam int OPM_RTC_CLR = 2;
  localparam int LVD_EN = 4;
  localparam int LVD_STAT = 7;

  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_TIME_MS = 125;
  localparam int RST_CYCLES =
    (RST_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_HZ = 32768;
  localparam int WDT_TIME_MS = 1500;
  localparam int WDT_TICKS = (WDT_TIME_MS * SLOW_HZ + 999) / 1000;

  // stable waits, in oscillator cycles
  localparam logic [10:0] FAST_STABLE = 11'h200;
  localparam logic [10:0] ISLOW_STABLE = 11'h004;
  localparam logic [10:0] XSLOW_STABLE = 11'h400;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_RUN = 3'b001,
    ST_STANDBY = 3'b011,
    ST_WAKE = 3'b111,
    ST_HALT = 3'b101
  } swr_state_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_SLOW = 2'h1,
    MODE_STANDBY = 2'h2,
    MODE_HALT = 2'h3
  } swr_mode_t;

  typedef struct packed {
    logic [2:0] timer;
    logic fast_tick;
    logic slow_tick;
    logic ext;
  } swr_wake_t;

  typedef struct packed {
    logic fast_osc_en;
    logic slow_clk_en;
    logic cpu_run;
    logic periph_en;
    logic cpu_clk_fast;
  } swr_clk_t;
endpackage : swr_pkg

// file: verilog/swr_ctrl.sv
`timescale 1ns/100ps
module swr_ctrl #(
  parameter int unsigned RST_CYCLES = swr_pkg::RST_CYCLES,
  parameter int unsigned WDT_TICKS = swr_pkg::WDT_TICKS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin,
  input wire logic supply_low,
  input wire logic lvd_below,
  input wire logic slow_xtal_sel,
  input wire logic wdt_option,
  input wire logic slow_clk_tick,
  input wire logic [15:0] port_pads,
  input wire logic [15:0] port_data,
  input wire swr_pkg::swr_wake_t wake_irq,
  output swr_pkg::swr_clk_t clk_ctrl,
  output logic [13:0] rtc_div,
  output logic sys_reset,
  output logic reset_vector_load
);
  localparam logic [22:0] RST_LAST = 23'(RST_CYCLES - 1);
  localparam logic [15:0] WDT_LAST = 16'(WDT_TICKS - 1);

  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    return (a[1:0] == 2'b00) && (a[7:2] == idx);
  endfunction : hit

  function automatic logic [10:0] stable_last(input logic fast,
                                              input logic xtal);
    if (fast) begin
      return swr_pkg::FAST_STABLE - 11'h001;
    end
    return (xtal ? swr_pkg::XSLOW_STABLE : swr_pkg::ISLOW_STABLE) - 11'h001;
  endfunction : stable_last

  swr_pkg::swr_state_t state;
  swr_pkg::swr_state_t next_state;
  logic [7:0] opmode;
  logic lvd_en;
  logic [3:0] last_cause;
  logic [22:0] rst_cnt;
  logic [10:0] wait_cnt;
  logic wait_fast;
  logic [15:0] wdt_cnt;
  logic wr_access;
  logic sleep_wr;
  logic wdclr_wr;
  logic opm_wr;
  logic mapped;
  logic key_change;
  logic wake_sb;
  logic wake_halt;
  logic rtc_step;
  logic wdt_expire;
  logic any_cause;
  logic wait_step;
  logic stable_done;
  logic [7:0] rd_mux;
  swr_pkg::swr_mode_t mode;

  // register slave: zero wait states, read data captured in setup phase
  assign pready = 1'b1;
  assign wr_access = psel & penable & pwrite;
  assign mapped = hit(paddr, swr_pkg::IDX_SLEEP)
                | hit(paddr, swr_pkg::IDX_WDCLR)
                | hit(paddr, swr_pkg::IDX_OPMODE)
                | hit(paddr, swr_pkg::IDX_LVD)
                | hit(paddr, swr_pkg::IDX_STAT);
  assign pslverr = psel & penable & ~mapped;
  assign sleep_wr = wr_access & hit(paddr, swr_pkg::IDX_SLEEP)
                  & (pwdata[7:0] == swr_pkg::SLEEP_CODE);
  assign wdclr_wr = wr_access & hit(paddr, swr_pkg::IDX_WDCLR)
                  & (pwdata[7:0] == swr_pkg::WDCLR_CODE);
  assign opm_wr = wr_access & hit(paddr, swr_pkg::IDX_OPMODE);

  // port data must mirror the pads before sleep, or this fires at once
  assign key_change = |(port_pads ^ port_data);
  assign wake_sb = key_change | (|wake_irq.timer) | wake_irq.fast_tick
                 | wake_irq.slow_tick | wake_irq.ext;
  assign wake_halt = key_change | wake_irq.ext;

  // divider and watchdog only advance while the slow clock runs
  assign rtc_step = slow_clk_tick & clk_ctrl.slow_clk_en
                  & opmode[swr_pkg::OPM_RTC_EN];
  assign wdt_expire = wdt_option & rtc_step & ~wdclr_wr
                    & (wdt_cnt == WDT_LAST);
  assign any_cause = reset_pin | supply_low | wdt_expire;

  assign wait_step = wait_fast | slow_clk_tick;
  assign stable_done = wait_step
                     & (wait_cnt == stable_last(wait_fast, slow_xtal_sel));

  always_comb begin
    next_state = state;
    case (state)
      swr_pkg::ST_RESET: begin
        if (rst_cnt == RST_LAST) begin
          next_state = swr_pkg::ST_RUN;
        end
      end
      swr_pkg::ST_RUN: begin
        if (sleep_wr) begin
          if (opmode[swr_pkg::OPM_RTC_EN]) begin
            next_state = swr_pkg::ST_STANDBY;
          end else begin
            next_state = swr_pkg::ST_HALT;
          end
        end
      end
      swr_pkg::ST_STANDBY: begin
        if (wake_sb) begin
          next_state = swr_pkg::ST_WAKE;
        end
      end
      swr_pkg::ST_HALT: begin
        if (wake_halt) begin
          next_state = swr_pkg::ST_WAKE;
        end
      end
      swr_pkg::ST_WAKE: begin
        if (stable_done) begin
          next_state = swr_pkg::ST_RUN;
        end
      end
      default: next_state = swr_pkg::ST_RESET;
    endcase
  end

  // a reset cause overrides any state, sleep included
  always_ff @(posedge ref_clk) begin
    if (!rst_n || any_cause) begin
      state <= swr_pkg::ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || any_cause || state != swr_pkg::ST_RESET) begin
      rst_cnt <= '0;
    end else begin
      rst_cnt <= rst_cnt + 23'h000001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reset_vector_load <= 1'b0;
    end else begin
      reset_vector_load <= (state == swr_pkg::ST_RESET) & ~any_cause
                         & (next_state == swr_pkg::ST_RUN);
    end
  end

  assign sys_reset = (state == swr_pkg::ST_RESET);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last_cause <= swr_pkg::CAUSE_POR;
    end else if (any_cause) begin
      last_cause <= {wdt_expire, reset_pin, supply_low, 1'b0};
    end
  end

  // wake wait counts fast cycles or slow ticks, chosen at wake entry
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wait_fast <= 1'b1;
    end else if (state != swr_pkg::ST_WAKE) begin
      wait_fast <= opmode[swr_pkg::OPM_CPU_FAST];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || state != swr_pkg::ST_WAKE) begin
      wait_cnt <= '0;
    end else if (wait_step) begin
      wait_cnt <= wait_cnt + 11'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || state == swr_pkg::ST_RESET) begin
      opmode <= swr_pkg::OPMODE_RST;
    end else if (opm_wr) begin
      opmode <= {pwdata[7:3], 3'b000};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || state == swr_pkg::ST_RESET) begin
      lvd_en <= 1'b0;
    end else if (wr_access && hit(paddr, swr_pkg::IDX_LVD)) begin
      lvd_en <= pwdata[swr_pkg::LVD_EN];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || state == swr_pkg::ST_RESET) begin
      rtc_div <= '0;
    end else if (opm_wr && !pwdata[swr_pkg::OPM_RTC_CLR]) begin
      rtc_div <= '0;
    end else if (rtc_step) begin
      rtc_div <= rtc_div + 14'h0001;
    end
  end

  // a clear write wins over a divider step in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n || state == swr_pkg::ST_RESET || wdclr_wr) begin
      wdt_cnt <= '0;
    end else if (wdt_option && rtc_step) begin
      wdt_cnt <= wdt_cnt + 16'h0001;
    end
  end

  always_comb begin
    clk_ctrl = '0;
    clk_ctrl.cpu_clk_fast = opmode[swr_pkg::OPM_CPU_FAST];
    case (state)
      swr_pkg::ST_RESET: begin
        clk_ctrl.fast_osc_en = 1'b1;
        clk_ctrl.slow_clk_en = 1'b1;
      end
      swr_pkg::ST_RUN: begin
        clk_ctrl.fast_osc_en = opmode[swr_pkg::OPM_CPU_FAST];
        clk_ctrl.slow_clk_en = opmode[swr_pkg::OPM_RTC_EN]
                             | ~opmode[swr_pkg::OPM_CPU_FAST];
        clk_ctrl.cpu_run = 1'b1;
        clk_ctrl.periph_en = 1'b1;
      end
      swr_pkg::ST_STANDBY: begin
        clk_ctrl.slow_clk_en = 1'b1;
        clk_ctrl.periph_en = 1'b1;
      end
      swr_pkg::ST_WAKE: begin
        clk_ctrl.fast_osc_en = wait_fast;
        clk_ctrl.slow_clk_en = ~wait_fast | opmode[swr_pkg::OPM_RTC_EN];
        clk_ctrl.periph_en = 1'b1;
      end
      swr_pkg::ST_HALT: begin
        clk_ctrl.slow_clk_en = 1'b0;
      end
      default: clk_ctrl.slow_clk_en = 1'b0;
    endcase
  end

  always_comb begin
    case (state)
      swr_pkg::ST_STANDBY: mode = swr_pkg::MODE_STANDBY;
      swr_pkg::ST_HALT: mode = swr_pkg::MODE_HALT;
      default: begin
        mode = opmode[swr_pkg::OPM_CPU_FAST] ? swr_pkg::MODE_NORMAL
                                             : swr_pkg::MODE_SLOW;
      end
    endcase
  end

  always_comb begin
    rd_mux = 8'h00;
    if (hit(paddr, swr_pkg::IDX_OPMODE)) begin
      rd_mux = opmode | 8'h04;
    end else if (hit(paddr, swr_pkg::IDX_LVD)) begin
      rd_mux[swr_pkg::LVD_EN] = lvd_en;
      rd_mux[swr_pkg::LVD_STAT] = lvd_en & lvd_below;
    end else if (hit(paddr, swr_pkg::IDX_STAT)) begin
      rd_mux = {2'b00, last_cause, mode};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rd_mux};
    end
  end

  // helper counters seen only by the checks below
  logic [22:0] rst_age;
  logic [10:0] wake_age;
  // restarts on every cause, so the length counts from the last one
  always_ff @(posedge ref_clk) begin
    if (!rst_n || state != swr_pkg::ST_RESET || any_cause) begin
      rst_age <= '0;
    end else if (rst_age != 23'h7FFFFF) begin
      rst_age <= rst_age + 23'h000001;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || state != swr_pkg::ST_WAKE) begin
      wake_age <= '0;
    end else if (wake_age != 11'h7FF) begin
      wake_age <= wake_age + 11'h001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_run_sleep;
    state == swr_pkg::ST_RUN && sleep_wr && !any_cause;
  endsequence
  sequence s_leave_wake;
    state == swr_pkg::ST_WAKE ##1 state == swr_pkg::ST_RUN;
  endsequence
  sequence s_leave_reset;
    state == swr_pkg::ST_RESET ##1 state == swr_pkg::ST_RUN;
  endsequence

  sleep_to_standby_a: assert property (
    s_run_sleep ##0 opmode[swr_pkg::OPM_RTC_EN]
    |=> state == swr_pkg::ST_STANDBY)
    else $error("sleep code with divider on missed standby");
  sleep_to_halt_a: assert property (
    s_run_sleep ##0 !opmode[swr_pkg::OPM_RTC_EN]
    |=> state == swr_pkg::ST_HALT)
    else $error("sleep code with divider off missed halt");
  standby_clocks_a: assert property (
    state == swr_pkg::ST_STANDBY |-> clk_ctrl.slow_clk_en
    && !clk_ctrl.fast_osc_en && !clk_ctrl.cpu_run)
    else $error("standby clock gating wrong");
  halt_clocks_a: assert property (
    state == swr_pkg::ST_HALT |-> !clk_ctrl.slow_clk_en
    && !clk_ctrl.fast_osc_en && !clk_ctrl.cpu_run && !clk_ctrl.periph_en)
    else $error("halt left a clock or peripheral on");
  standby_wake_a: assert property (
    state == swr_pkg::ST_STANDBY && wake_sb && !any_cause
    |=> state == swr_pkg::ST_WAKE)
    else $error("standby did not wake");
  halt_hold_a: assert property (
    state == swr_pkg::ST_HALT && !wake_halt && !any_cause
    |=> state == swr_pkg::ST_HALT)
    else $error("halt left without key or external event");
  key_wake_a: assert property (
    state == swr_pkg::ST_HALT && (port_pads != port_data) && !any_cause
    |=> state == swr_pkg::ST_WAKE)
    else $error("key mismatch did not wake halt");
  fast_wait_a: assert property (
    s_leave_wake ##0 $past(wait_fast, 1) |-> $past(wake_age, 1) == 11'h1FF)
    else $error("fast stable wait not 512 cycles");
  slow_wait_a: assert property (
    s_leave_wake ##0 !$past(wait_fast, 1) |-> $past(slow_clk_tick, 1))
    else $error("slow stable wait ended off a slow tick");
  wake_mode_a: assert property (
    s_leave_wake |-> clk_ctrl.cpu_run
    && ((mode == swr_pkg::MODE_NORMAL) == opmode[swr_pkg::OPM_CPU_FAST]))
    else $error("wake returned to wrong run mode");
  reset_length_a: assert property (
    s_leave_reset |-> $past(rst_age, 1) == RST_LAST)
    else $error("reset procedure length wrong");
  reset_vector_a: assert property (
    s_leave_reset |-> reset_vector_load && opmode[swr_pkg::OPM_CPU_FAST])
    else $error("reset exit without vector load in normal mode");
  reset_cause_a: assert property (
    reset_pin || supply_low |=> state == swr_pkg::ST_RESET)
    else $error("reset cause ignored");
  wdt_timeout_a: assert property (
    wdt_option && rtc_step && !wdclr_wr && wdt_cnt == WDT_LAST
    |=> state == swr_pkg::ST_RESET ##1 state == swr_pkg::ST_RESET)
    else $error("watchdog timeout did not reset");
  wdt_clear_a: assert property (
    wdclr_wr |=> wdt_cnt == 16'h0000)
    else $error("watchdog clear ignored");
  bad_code_a: assert property (
    state == swr_pkg::ST_RUN && wr_access && !any_cause
    && hit(paddr, swr_pkg::IDX_SLEEP)
    && pwdata[7:0] != swr_pkg::SLEEP_CODE |=> state == swr_pkg::ST_RUN)
    else $error("wrong sleep code changed mode");
endmodule : swr_ctrl

// file: verif/sleep_wake_reset_control_test.sv
`timescale 1ns/100ps
module sleep_wake_reset_control_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic reset_pin = 1'b0;
  logic supply_low = 1'b0;
  logic lvd_below = 1'b0;
  logic slow_xtal_sel = 1'b0;
  logic wdt_option = 1'b0;
  logic slow_clk_tick = 1'b0;
  logic [15:0] port_pads = 16'h0;
  logic [15:0] port_data = 16'h0;
  swr_pkg::swr_wake_t wake_irq = '0;
  swr_pkg::swr_clk_t clk_ctrl;
  logic [13:0] rtc_div;
  logic sys_reset;
  logic reset_vector_load;
  logic [31:0] rd;
  logic err;
  logic [2:0] tick_cnt = 3'h0;
  int fails = 0;
  int cmp_count = 0;
  int n;
  int k;
  int cyc = 0;

  swr_ctrl #(.RST_CYCLES(20), .WDT_TICKS(8)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_pin(reset_pin),
    .supply_low(supply_low), .lvd_below(lvd_below),
    .slow_xtal_sel(slow_xtal_sel), .wdt_option(wdt_option),
    .slow_clk_tick(slow_clk_tick), .port_pads(port_pads),
    .port_data(port_data), .wake_irq(wake_irq), .clk_ctrl(clk_ctrl),
    .rtc_div(rtc_div), .sys_reset(sys_reset),
    .reset_vector_load(reset_vector_load)
  );

  always #10 ref_clk = ~ref_clk;

  // slow oscillator ticks every 8 cycles, only while the block enables it
  always @(posedge ref_clk) begin
    tick_cnt <= tick_cnt + 3'h1;
    slow_clk_tick <= (tick_cnt == 3'h7) && (clk_ctrl.slow_clk_en === 1'b1);
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask : rd_chk

  // counts edges until the cpu clock runs again
  task automatic wait_run(output int cnt);
    cnt = 0;
    @(posedge ref_clk);
    while (clk_ctrl.cpu_run !== 1'b1 && cnt < 9000) begin
      @(posedge ref_clk);
      cnt++;
    end
  endtask : wait_run

  task automatic wait_rst(output int cnt);
    logic seen;
    cnt = 0;
    while (sys_reset !== 1'b0 && cnt < 500) begin
      @(posedge ref_clk);
      cnt++;
    end
    seen = reset_vector_load;
    @(posedge ref_clk);
    seen = seen | reset_vector_load;
    chk(seen, 1'b1);
  endtask : wait_rst

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_rst(n);
    chk(n >= 20 && n <= 24, 1'b1);
    rd_chk(8'h74, 32'h04);
    apb(1'b0, 8'h5C, 8'h00);
    chk(rd[7:0] & 8'h88, 8'h88);
    chk(clk_ctrl.cpu_clk_fast, 1'b1);
    apb(1'b1, 8'h54, 8'h00);
    rd_chk(8'h74, 32'h04);
    apb(1'b0, 8'h00, 8'h00);
    chk({err, rd[30:0]}, 32'h8000_0000);
    // standby, each wake source in turn, last one a key change
    for (int i = 0; i < 7; i++) begin
      port_pads <= 16'h00A5;
      port_data <= 16'h00A5;
      apb(1'b1, 8'h54, 8'h5A);
      rd_chk(8'h74, 32'h06);
      chk({clk_ctrl.fast_osc_en, clk_ctrl.slow_clk_en, clk_ctrl.cpu_run},
          3'b010);
      if (i < 6) begin
        wake_irq <= 6'h01 << i;
      end else begin
        port_pads <= 16'h00A4;
      end
      wait_run(n);
      chk(n >= 511 && n <= 516, 1'b1);
      wake_irq <= '0;
      chk(clk_ctrl.cpu_clk_fast, 1'b1);
      rd_chk(8'h74, 32'h04);
    end
    // halt from slow mode with divider off, both slow sources
    apb(1'b1, 8'h5C, 8'h04);
    for (int s = 0; s < 2; s++) begin
      slow_xtal_sel <= s[0];
      port_pads <= 16'h0;
      port_data <= 16'h0;
      apb(1'b1, 8'h54, 8'h5A);
      @(posedge ref_clk);
      chk({clk_ctrl.fast_osc_en, clk_ctrl.slow_clk_en, clk_ctrl.cpu_run,
           clk_ctrl.periph_en}, 4'b0000);
      wake_irq <= 6'b111110;
      repeat (40) @(posedge ref_clk);
      rd_chk(8'h74, 32'h07);
      wake_irq <= (s == 0) ? 6'h01 : 6'h00;
      port_pads <= (s == 1) ? 16'h0100 : 16'h0000;
      wait_run(n);
      k = (s == 1) ? 1024 : 4;
      chk(n >= (k - 1) * 8 && n <= k * 8 + 10, 1'b1);
      wake_irq <= '0;
      chk(clk_ctrl.cpu_clk_fast, 1'b0);
      rd_chk(8'h74, 32'h05);
    end
    // reset pin while in standby
    apb(1'b1, 8'h5C, 8'h8C);
    port_pads <= 16'h0;
    apb(1'b1, 8'h54, 8'h5A);
    reset_pin <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(sys_reset, 1'b1);
    reset_pin <= 1'b0;
    wait_rst(n);
    chk(n >= 20 && n <= 24, 1'b1);
    rd_chk(8'h74, 32'h10);
    supply_low <= 1'b1;
    repeat (2) @(posedge ref_clk);
    supply_low <= 1'b0;
    wait_rst(n);
    rd_chk(8'h74, 32'h08);
    apb(1'b1, 8'h70, 8'h10);
    lvd_below <= 1'b1;
    rd_chk(8'h70, 32'h90);
    lvd_below <= 1'b0;
    rd_chk(8'h70, 32'h10);
    repeat (16) @(posedge ref_clk);
    chk(rtc_div != 14'h0000, 1'b1);
    apb(1'b1, 8'h5C, 8'h88);
    @(posedge ref_clk);
    chk(rtc_div, 32'h0);
    // watchdog kept alive, then a wrong code lets it expire
    wdt_option <= 1'b1;
    repeat (6) begin
      repeat (40) @(posedge ref_clk);
      apb(1'b1, 8'h58, 8'hA5);
    end
    rd_chk(8'h74, 32'h08);
    // wrong code lands mid-period: a clear here would push expiry past 40
    repeat (27) @(posedge ref_clk);
    apb(1'b1, 8'h58, 8'h00);
    n = 0;
    while (sys_reset !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n < 40, 1'b1);
    wdt_option <= 1'b0;
    wait_rst(n);
    rd_chk(8'h74, 32'h20);
    end_of_test();
  end
endmodule : sleep_wake_reset_control_test
